/* src/flash_status_dev.sv */
// Chosen here: the register addresses and strobed register access.
`timescale 1ns/10ps
module flash_status_dev #(
    parameter int WRITE_CYCLES = flash_status_pkg::STATUS_WRITE_CYCLES,
    parameter int ADDR_W       = flash_status_pkg::ADDR_W
) (
    input  wire logic              core_clk,
    input  wire logic              rst,
    flash_link_if.dev              link,
    input  wire logic              fourLineMode,  // four-line command mode active
    input  wire logic [7:0]        memData,       // array byte at memAddr
    output logic      [ADDR_W-1:0] memAddr,
    output logic                   memWriteStart, // accepted page write/clear, one pulse
    output logic      [7:0]        memWriteOp,
    output logic      [ADDR_W-1:0] memWriteAddr,
    input  wire logic              memBusy,       // array cycle in progress
    input  wire logic [ADDR_W-1:0] protLow,       // lowest protected address for level
    output logic      [7:0]        statusView,
    output logic                   hardwareGuard
);
    import flash_status_pkg::*;

    // two-flop synchronisers for all pins
    logic [1:0] selS, clkS, mosiS, wpS;
    logic       clkLast, selLast;
    always_ff @(posedge core_clk or posedge rst)
    begin
        if (rst)
        begin
            selS <= 2'h3; clkS <= 2'h0; mosiS <= 2'h0; wpS <= 2'h3;
            clkLast <= 1'b0; selLast <= 1'b1;
        end
        else
        begin
            selS <= {selS[0], link.selectN}; clkS <= {clkS[0], link.sclk};
            mosiS <= {mosiS[0], link.mosi}; wpS <= {wpS[0], link.guardPinN};
            clkLast <= clkS[1]; selLast <= selS[1];
        end
    end

    wire selected = ~selS[1];
    wire riseEdge = selected & clkS[1] & ~clkLast;
    wire fallEdge = selected & ~clkS[1] & clkLast;
    wire selRise  = selS[1] & ~selLast;

    logic [7:0]        stat;      // non-volatile bits 7..2 plus latch; bit 0 stays zero, busy comes from busyNow
    logic              wrBusy;
    logic [15:0]       wrCount;
    logic [7:0]        shiftIn, opcode, wrData;
    logic [5:0]        bitCnt;    // bits taken this frame, saturates
    logic [ADDR_W-1:0] addr;
    logic [7:0]        outShift;
    logic [2:0]        outBit;
    logic              outEn;

    // protection decode, shared by several paths
    wire hwGuard   = stat[LOCK_BIT] & ~wpS[1] & ~fourLineMode & ~stat[QUAD_BIT];
    wire quadOk    = stat[QUAD_BIT] | fourLineMode;
    wire busyNow   = wrBusy | memBusy;
    wire [3:0] lvl = stat[5:2];
    wire byteDone  = riseEdge & (bitCnt[2:0] == 3'h7);
    wire [7:0] inByte = {shiftIn[6:0], mosiS[1]};
    wire isChip    = (opcode == OP_CHIP_A) | (opcode == OP_CHIP_B);
    wire isAddrCmd = (opcode == OP_PAGE) | (opcode == OP_SECT) | (opcode == OP_HALFBLK) |
                     (opcode == OP_BLOCK) | ((opcode == OP_QPAGE) & quadOk);
    wire inProt    = (lvl != 4'h0) & (addr >= protLow);
    wire statWrOk  = (opcode == OP_STAT_WRITE) & (bitCnt == 6'd16) & stat[LATCH_BIT] & ~hwGuard & ~busyNow;
    wire addrOk    = isAddrCmd & (bitCnt >= 6'd32) & stat[LATCH_BIT] & ~busyNow & ~inProt;
    wire chipOk    = isChip & (bitCnt == 6'd8) & stat[LATCH_BIT] & ~busyNow & (lvl == 4'h0);
    wire doWrite   = selRise & (addrOk | chipOk);
    wire readCmd   = (opcode == OP_READ) & (bitCnt >= 6'd32);

    // frame receiver: opcode, address, status data
    always_ff @(posedge core_clk or posedge rst)
    begin
        if (rst)
        begin
            shiftIn <= 8'h00; opcode <= 8'h00; wrData <= 8'h00; bitCnt <= 6'h00; addr <= '0;
        end
        else if (!selected)
            bitCnt <= 6'h00;
        else if (riseEdge)
        begin
            shiftIn <= inByte;
            if (bitCnt != 6'h3f)
                bitCnt <= bitCnt + 6'h01;
            if (byteDone && bitCnt == 6'd7)
                opcode <= inByte;
            if (byteDone && bitCnt == 6'd15)
                wrData <= inByte;
            if (bitCnt >= 6'd8 && bitCnt < 6'd32)
                addr <= {addr[ADDR_W-2:0], mosiS[1]};
        end
        // step on the last bit of a byte, so the next boundary loads the new address
        else if (fallEdge && readCmd && outBit == 3'h7)
            addr <= addr + ADDR_W'(1);
    end

    // status register and status-write timer
    always_ff @(posedge core_clk or posedge rst)
    begin
        if (rst)
        begin
            stat <= STATUS_RESET; wrBusy <= 1'b0; wrCount <= 16'h0000;
        end
        else
        begin
            if (selRise && statWrOk)
            begin
                // busy and latch untouched by data
                stat[7:2] <= wrData[7:2];
                wrBusy    <= 1'b1;
                wrCount   <= 16'(WRITE_CYCLES);
            end
            else if (wrBusy)
            begin
                if (wrCount <= 16'h0001)
                begin
                    wrBusy <= 1'b0;
                    stat[LATCH_BIT] <= 1'b0;
                end
                wrCount <= wrCount - 16'h0001;
            end
            else if (selRise && bitCnt == 6'd8 && opcode == OP_LATCH_SET && !busyNow)
                stat[LATCH_BIT] <= 1'b1;
            else if (selRise && bitCnt == 6'd8 && opcode == OP_WRDI && !busyNow)
                stat[LATCH_BIT] <= 1'b0;
            else if (doWrite)
                stat[LATCH_BIT] <= 1'b0;
        end
    end

    // data out: status or array byte, changes on falling edges
    always_ff @(posedge core_clk or posedge rst)
    begin
        if (rst)
        begin
            outShift <= 8'h00; outBit <= 3'h0; outEn <= 1'b0;
        end
        else if (!selected)
        begin
            outEn <= 1'b0; outBit <= 3'h0;
        end
        else if (fallEdge && ((opcode == OP_STAT_READ && bitCnt >= 6'd8) || readCmd))
        begin
            outEn  <= 1'b1;
            outBit <= outBit + 3'h1;
            if (outBit == 3'h0)
                outShift <= (opcode == OP_STAT_READ) ? {stat[7:1], busyNow} : memData;
            else
                outShift <= {outShift[6:0], 1'b0};
        end
    end

    // memory side requests, only the quad page write opcode honours quad enable; quad reads are not decoded
    always_ff @(posedge core_clk or posedge rst)
    begin
        if (rst)
        begin
            memWriteStart <= 1'b0; memWriteOp <= 8'h00; memWriteAddr <= '0;
        end
        else
        begin
            memWriteStart <= doWrite;
            if (doWrite)
            begin
                memWriteOp   <= opcode;
                memWriteAddr <= addr;
            end
        end
    end

    assign link.miso     = (outBit == 3'h1) ? (opcode == OP_STAT_READ ? stat[7] : memData[7]) : outShift[7];
    assign link.misoOeN  = ~outEn;
    assign memAddr       = addr;
    assign statusView    = {stat[7:1], busyNow};
    assign hardwareGuard = hwGuard;
endmodule

/* src/flash_status_pkg.sv */
package flash_status_pkg;
    localparam logic [7:0] OP_READ      = 8'h03;
    localparam logic [7:0] OP_LATCH_SET = 8'h06;
    localparam logic [7:0] OP_WRDI      = 8'h04;
    localparam logic [7:0] OP_STAT_READ = 8'h05;
    localparam logic [7:0] OP_STAT_WRITE = 8'h01;
    localparam logic [7:0] OP_PAGE      = 8'h02;
    localparam logic [7:0] OP_QPAGE     = 8'h38;
    localparam logic [7:0] OP_SECT      = 8'h20;
    localparam logic [7:0] OP_HALFBLK   = 8'h52;
    localparam logic [7:0] OP_BLOCK     = 8'hd8;
    localparam logic [7:0] OP_CHIP_A    = 8'h60;
    localparam logic [7:0] OP_CHIP_B    = 8'hc7;
    localparam logic [7:0] OP_QREAD     = 8'heb;
    localparam logic [7:0] OP_WQREAD    = 8'he7;
    // status bit positions
    localparam int BUSY_BIT  = 0;
    localparam int LATCH_BIT = 1;
    localparam int PROT_LSB  = 2;
    localparam int QUAD_BIT  = 6;
    localparam int LOCK_BIT  = 7;
    localparam logic [7:0] STATUS_RESET = 8'h00;
    localparam logic [7:0] STATUS_WMASK = 8'hfc;
    localparam int ADDR_W    = 23;
    // status write time in ns, and clock period in ns
    localparam int STATUS_WRITE_TIME_NS = 10000;
    localparam int CLK_PERIOD_NS        = 50;
    localparam int STATUS_WRITE_CYCLES  = (STATUS_WRITE_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int SCLK_HALF_CYCLES     = 4;
endpackage

/* src/flash_link_if.sv */
`timescale 1ns/10ps
interface flash_link_if;
    logic selectN;    // chip select, active low
    logic sclk;
    logic mosi;
    logic miso;
    logic misoOeN;    // low while device drives data out
    logic guardPinN;  // write-protect, active low
    modport dev  (input selectN, input sclk, input mosi, input guardPinN, output miso, output misoOeN);
    modport host (output selectN, output sclk, output mosi, output guardPinN, input miso, input misoOeN);
endinterface

/* src/flash_status_host.sv */
`timescale 1ns/10ps
module flash_status_host #(
    parameter int HALF = flash_status_pkg::SCLK_HALF_CYCLES
) (
    input  wire logic       core_clk,
    input  wire logic       rst,
    flash_link_if.host      link,
    input  wire logic       cmdStart,   // one-cycle pulse
    input  wire logic [7:0] cmdOp,
    input  wire logic [23:0] cmdAddr,
    input  wire logic [7:0] cmdData,
    input  wire logic [5:0] cmdBytes,   // total bytes in frame incl. opcode
    input  wire logic       guardLevel, // write-protect level to drive
    output logic            cmdBusy,
    output logic [7:0]      rxByte,
    output logic            rxValid
);
    import flash_status_pkg::*;
    logic [1:0] misoS;
    logic [7:0] txShift, rxShift;
    logic [2:0] bitIdx;
    logic [5:0] bytesLeft;
    logic [23:0] addrHold;
    logic [7:0] dataHold;
    logic [7:0] div;
    logic       sclkR, active;
    wire        tick = active & (div == 8'(HALF - 1));

    // frame engine: mode 0, sends msb first, bits change on falling edges
    always_ff @(posedge core_clk or posedge rst)
    begin
        if (rst)
        begin
            misoS <= 2'h0; txShift <= 8'h00; rxShift <= 8'h00; bitIdx <= 3'h0; bytesLeft <= 6'h00;
            addrHold <= 24'h0; dataHold <= 8'h00; div <= 8'h00; sclkR <= 1'b0; active <= 1'b0;
            rxByte <= 8'h00; rxValid <= 1'b0;
        end
        else
        begin
            misoS   <= {misoS[0], link.miso};
            rxValid <= 1'b0;
            div     <= tick ? 8'h00 : (active ? div + 8'h01 : 8'h00);
            if (cmdStart && !active)
            begin
                active <= 1'b1; txShift <= cmdOp; bytesLeft <= cmdBytes; bitIdx <= 3'h0;
                addrHold <= cmdAddr; dataHold <= cmdData;
            end
            else if (tick && !sclkR)
                sclkR   <= 1'b1;
            else if (tick && sclkR)
            begin
                // sampled late in the high phase: the round trip through both ends' sync flops exceeds half a period
                sclkR   <= 1'b0;
                bitIdx  <= bitIdx + 3'h1;
                rxShift <= {rxShift[6:0], misoS[1]};
                if (bitIdx == 3'h7)
                begin
                    rxByte <= {rxShift[6:0], misoS[1]}; rxValid <= 1'b1;
                    // raise select only on a byte boundary
                    if (bytesLeft <= 6'h01)
                        active <= 1'b0;
                    bytesLeft <= bytesLeft - 6'h01;
                    txShift   <= (bytesLeft > 6'd2) ? addrHold[23:16] : dataHold;
                    addrHold  <= {addrHold[15:0], 8'h00};
                end
                else
                    txShift <= {txShift[6:0], 1'b0};
            end
        end
    end

    assign link.selectN   = ~active;
    assign link.sclk      = sclkR;
    assign link.mosi      = txShift[7];
    assign link.guardPinN = guardLevel;
    assign cmdBusy        = active;
endmodule

/* sim/flash_status_asserts.sv */
`timescale 1ns/10ps
module flash_status_asserts #(
    parameter int WRITE_CYCLES = 120
) (
    input wire logic       core_clk,
    input wire logic       rst,
    input wire logic       selectN,
    input wire logic       sclk,
    input wire logic       miso,
    input wire logic       misoOeN,
    input wire logic       guardPinN,
    input wire logic       fourLineMode,
    input wire logic [7:0] statusView,
    input wire logic       hardwareGuard
);
    localparam int LO = WRITE_CYCLES - 2;
    localparam int HI = WRITE_CYCLES + 4;
    logic [15:0] busyCnt;
    default clocking @(posedge core_clk); endclocking
    default disable iff (rst);
    // length of the running busy stretch, read back at the edge where it ends
    always_ff @(posedge core_clk or posedge rst)
        if (rst)
            busyCnt <= 16'h0;
        else
            busyCnt <= statusView[0] ? busyCnt + 16'h1 : 16'h0;
    sequence s_busy_on; $rose(statusView[0]); endsequence
    sequence s_busy_hold; (statusView[0] && statusView[1]) [*8]; endsequence
    // pins pass two sync flops, so relations are judged once inputs have settled
    property p_busy_hold; s_busy_on |-> s_busy_hold; endproperty
    property p_busy_len; $fell(statusView[0]) |-> busyCnt >= LO && busyCnt <= HI; endproperty
    property p_busy_clear; $fell(statusView[0]) |-> !statusView[1]; endproperty
    property p_guard; ($stable(guardPinN) && $stable(fourLineMode)) [*4]
        |-> hardwareGuard == (statusView[7] && !guardPinN && !statusView[6] && !fourLineMode); endproperty
    property p_lock_hold; hardwareGuard && $past(hardwareGuard) |-> $stable(statusView[7:2]); endproperty
    property p_oe_off; selectN [*4] |-> misoOeN; endproperty
    property p_miso_fall; !misoOeN && $changed(miso) |-> !sclk; endproperty
    property p_sclk_idle; selectN |-> !sclk; endproperty
    a_busy_hold: assert property (p_busy_hold) else $error("busy dropped early");
    a_busy_len: assert property (p_busy_len) else $error("busy length off");
    a_busy_clear: assert property (p_busy_clear) else $error("latch kept after write");
    a_guard: assert property (p_guard) else $error("guard state wrong");
    a_lock_hold: assert property (p_lock_hold) else $error("locked bits changed");
    a_oe_off: assert property (p_oe_off) else $error("data out driven unselected");
    a_miso_fall: assert property (p_miso_fall) else $error("data out moved on high clock");
    a_sclk_idle: assert property (p_sclk_idle) else $error("link clock runs idle");
endmodule

/* sim/tb_top.sv */
`timescale 1ns/10ps
module tb_top;
    import flash_status_pkg::*;
    localparam int WCYC = 120;
    logic              core_clk = 1'b0;
    logic              rst = 1'b1;
    logic              cmdStart = 1'b0;
    logic [7:0]        cmdOp = 8'h00;
    logic [23:0]       cmdAddr = 24'h0;
    logic [7:0]        cmdData = 8'h00;
    logic [5:0]        cmdBytes = 6'h0;
    logic              guardLevel = 1'b0;
    logic              fourLineMode = 1'b0;
    logic              cmdBusy, rxValid, memWriteStart, hardwareGuard;
    logic [7:0]        rxByte, memData, statusView, v;
    logic [ADDR_W-1:0] memAddr, ra, ea, wAddr;
    logic [15:0]       note;
    logic [15:0]       q[$];
    logic [15:0]       want[$];
    logic [31:0]       rnd = 32'hd7b306ea;
    int                num_errors = 0;
    int                comparisons = 0;
    int                writes = 0;
    int                i, j;
    flash_link_if lnk();
    flash_status_dev #(.WRITE_CYCLES(WCYC)) u_flash_status_dev (.core_clk(core_clk), .rst(rst), .link(lnk),
        .fourLineMode(fourLineMode), .memData(memData), .memAddr(memAddr), .memWriteStart(memWriteStart),
        .memWriteOp(), .memWriteAddr(wAddr), .memBusy(1'b0), .protLow(23'h400000), .statusView(statusView),
        .hardwareGuard(hardwareGuard));
    flash_status_host u_flash_status_host (.core_clk(core_clk), .rst(rst), .link(lnk), .cmdStart(cmdStart),
        .cmdOp(cmdOp), .cmdAddr(cmdAddr), .cmdData(cmdData), .cmdBytes(cmdBytes), .guardLevel(guardLevel),
        .cmdBusy(cmdBusy), .rxByte(rxByte), .rxValid(rxValid));
    flash_status_asserts #(.WRITE_CYCLES(WCYC)) u_flash_status_asserts (.core_clk(core_clk), .rst(rst),
        .selectN(lnk.selectN), .sclk(lnk.sclk), .miso(lnk.miso), .misoOeN(lnk.misoOeN),
        .guardPinN(lnk.guardPinN), .fourLineMode(fourLineMode), .statusView(statusView),
        .hardwareGuard(hardwareGuard));
    // array contents follow the address, so a wrong or stuck counter shows up
    assign memData = memAddr[7:0] ^ {1'b0, memAddr[22:16]};
    always #25 core_clk = ~core_clk;
    function automatic logic [31:0] lfsr(input logic [31:0] x);
        return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
    endfunction
    task automatic check(input logic [7:0] got, input logic [7:0] exp);
        comparisons++;
        if (got !== exp)
        begin
            num_errors++;
            $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    // notes don't-care bytes first, then whatever the caller staged for the tail
    task automatic frame(input logic [7:0] op, input logic [23:0] a, input logic [7:0] d, input logic [5:0] n);
        int k;
        for (k = want.size(); k < n; k++)
            q.push_back(16'h0);
        while (want.size() > 0)
            q.push_back(want.pop_front());
        cmdOp <= op;
        cmdAddr <= a;
        cmdData <= d;
        cmdBytes <= n;
        cmdStart <= 1'b1;
        @(posedge core_clk);
        cmdStart <= 1'b0;
        repeat (3) @(posedge core_clk);
        for (k = 0; k < 4000 && cmdBusy !== 1'b0; k++)
            @(posedge core_clk);
        repeat (8) @(posedge core_clk);
    endtask
    task automatic readStat(input logic [7:0] m, input logic [7:0] e);
        want.push_back({m, e});
        frame(OP_STAT_READ, 24'h0, 8'h00, 6'd2);
    endtask
    task automatic wsr(input logic [7:0] d);
        frame(OP_LATCH_SET, 24'h0, 8'h00, 6'd1);
        frame(OP_STAT_WRITE, 24'h0, d, 6'd2);
        repeat (WCYC + 20) @(posedge core_clk);
    endtask
    task automatic close_out;
        $display("comparisons %0d mismatches %0d", comparisons, num_errors);
        if (num_errors == 0 && comparisons > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask
    // received bytes are judged against the oldest note; a zero mask skips it
    always @(posedge core_clk)
        if (rxValid === 1'b1)
        begin
            note = (q.size() > 0) ? q.pop_front() : 16'hff5a;
            if (note[15:8] != 8'h00)
                check(rxByte & note[15:8], note[7:0]);
        end
    always @(posedge core_clk)
        if (memWriteStart === 1'b1)
        begin
            writes++;
            check(wAddr[7:0], 8'h10);
        end
    initial
    begin
        #2000000;
        num_errors++;
        close_out;
    end
    initial
    begin
        repeat (12) @(posedge core_clk);
        rst <= 1'b0;
        @(posedge core_clk);
        readStat(8'hff, 8'h00);
        frame(OP_LATCH_SET, 24'h0, 8'h00, 6'd1);
        readStat(8'hff, 8'h02);
        frame(OP_STAT_WRITE, 24'h0, 8'hbc, 6'd3);
        readStat(8'hfc, 8'h00);
        frame(OP_LATCH_SET, 24'h0, 8'h00, 6'd1);
        frame(OP_STAT_WRITE, 24'h0, 8'hbc, 6'd2);
        // new bits already show while the cycle runs with busy and latch up
        readStat(8'hff, 8'hbf);
        repeat (WCYC) @(posedge core_clk);
        readStat(8'hff, 8'hbc);
        $display("status write test done");
        wsr(8'h00);
        readStat(8'hfc, 8'hbc);
        fourLineMode <= 1'b1;
        repeat (8) @(posedge core_clk);
        fourLineMode <= 1'b0;
        // only the first write lies below the protect limit with quad off
        for (i = 0; i < 8; i++)
        begin
            frame(OP_LATCH_SET, 24'h0, 8'h00, 6'd1);
            frame((i == 0) ? OP_PAGE : (i == 1) ? OP_QPAGE : (i == 2) ? OP_CHIP_B : OP_PAGE,
                (i == 0) ? 24'h000010 : 24'h7fff00, 8'h5a, (i == 2) ? 6'd1 : 6'd5);
        end
        check(writes[7:0], 8'h01);
        $display("protection test done");
        guardLevel <= 1'b1;
        rnd = lfsr(rnd);
        v = 8'hc0 | (rnd[7:0] & 8'h3c);
        wsr(v);
        readStat(8'hff, v);
        guardLevel <= 1'b0;
        frame(OP_LATCH_SET, 24'h0, 8'h00, 6'd1);
        frame(OP_QPAGE, 24'h000010, 8'h5a, 6'd5);
        check(writes[7:0], 8'h02);
        wsr(8'h00);
        frame(OP_STAT_WRITE, 24'h0, 8'h3c, 6'd2);
        repeat (WCYC + 20) @(posedge core_clk);
        readStat(8'hff, 8'h00);
        $display("quad and latch test done");
        for (i = 0; i < 3; i++)
        begin
            rnd = lfsr(rnd);
            ra = (i == 0) ? 23'h7ffffe : rnd[22:0];
            for (j = 0; j < 3; j++)
            begin
                ea = ra + 23'(j);
                want.push_back({8'hff, ea[7:0] ^ {1'b0, ea[22:16]}});
            end
            frame(OP_READ, {1'b0, ra}, 8'h00, 6'd7);
        end
        $display("read test done");
        close_out;
    end
endmodule
